//--- tdm_partner.sv
// Purpose: far tdm device giving bus clock, frame sync and slot data
// Assumes: bus clock runs free, so the port sees edges during reset
// Notes: outside a frame the data line shows the inverse of its last level
`timescale 1ns/1ps

module tdm_partner (
    // control
    input wire logic run_i,
    input wire logic [3:0] delay_i,
    input wire logic [15:0] period_i,
    input wire logic [15:0] glitch_i,
    // bus
    output logic sclk_o,
    output logic fs_o,
    output logic sdi_o,
    output int cyc_o,
    output logic [15:0] word_o
);
    int c;
    int j;
    int p;
    logic [15:0] w;

    // ****
    // bus clock
    // ****
    // one clock serves both directions
    initial begin
        sclk_o = 1'b0;
        forever #80 sclk_o = ~sclk_o;
    end

    // ****
    // framing
    // ****
    // sync and data change on the falling edge, sampled on the rising
    initial begin
        fs_o = 1'b0;
        sdi_o = 1'b0;
        cyc_o = -1;
        word_o = 16'h0000;
    end
    always @(negedge sclk_o) begin
        p = period_i;
        c = run_i ? cyc_o + 1 : -1;
        j = c - delay_i;
        w = j < 0 ? 16'h0000 : 16'h5a00 ^ 16'((j % p) / 16 * 263);
        cyc_o <= c;
        fs_o <= c >= 0 && c < 2 * p && (c % p == 0 || c % p == glitch_i);
        word_o <= w;
        sdi_o <= j < 0 ? ~sdi_o : w[15 - j % 16];
    end
endmodule : tdm_partner

//--- tdm_pkg.sv
// Purpose: shared constants for the tdm framing block
// Assumes: one serial port, slots of up to 16 bits
// Notes: all counts are in serial clock cycles

package tdm_pkg;

    // ************************************
    // sizes
    // ************************************
    localparam int WORD_BITS_DEF = 16;
    localparam int WORD_BITS_MIN = 3;
    localparam int SLOT_MAX = 128;
    localparam int SLOT_W = 8;
    localparam int INDEX_W = 7;
    localparam int DELAY_W = 4;
    localparam int WSIZE_W = 4;
    localparam int WIN_STEP_LOG = 3;
    localparam int PFD_W = 2;
    localparam int DIV_W = 8;
    localparam int BIT_W = 4;

    // ************************************
    // reset values and codes
    // ************************************
    localparam logic [15:0] WORD_RST = 16'h0000;
    localparam logic [SLOT_W-1:0] PREFETCH_BASE = 8'h02;

    typedef enum logic [2:0] {
        ST_IDLE = 3'b001,
        ST_DELAY = 3'b010,
        ST_RUN = 3'b100
    } frame_state_e;

endpackage : tdm_pkg

//--- tdm_serial_port_framing.sv
// Purpose: transmit framing and multichannel slot engine of a serial port
// Assumes: serial clock on sclk_i serves transmit and receive alike
// Notes: config is quasi-static and is synchronised into the link domain
// Operation
// - without free run, internal sync waits for a freshly written word
// - with free run, internal sync fires each interval, resending old word
// - resending a stale word, internal or external sync, sets underflow
// - up to 128 slots, each transmit, receive, both or none
// - enabled transmitter always drives data, except inactive multichannel slots
// - in multichannel mode transmit clock is the receive clock
// - receive sync frames both directions and restarts at slot zero
// - multichannel forces late framing; zero delay puts bit in sync cycle
// - transmit sync marks enabled transmit slots; data off elsewhere
// - syncs are ignored until the whole frame is done
// - four-bit frame delay of 0 to 15 cycles before first bit
// - window size 8 to 128 in steps of 8, code zero is 8
// - window offset sets first window slot, zero means none
// - window beyond select maps enables no slot
// - frame slot count is offset plus window size
// - select offset mode maps bit zero to first slot after offset
// - seven-bit slot index counts slots, restarts after offset in offset mode
// - alignment clear launches data with sync edge, set launches on falling edge
// - select maps hold one enable per slot, cleared transmit bit releases data
// - one enable turns multichannel on for both directions
// - two-bit prefetch limit of 2, 4, 8 or 16 slots ahead
`timescale 1ns/1ps

module tdm_serial_port_framing import tdm_pkg::*; #(
    parameter int WORD_BITS = WORD_BITS_DEF
) (
    // system side
    input wire logic clk_i,
    input wire logic rst_b_i,
    // configuration
    input wire logic tx_port_enable_i,
    input wire logic rx_port_enable_i,
    input wire logic multichannel_enable_i,
    input wire logic tx_sync_internal_i,
    input wire logic rx_sync_internal_i,
    input wire logic tx_sync_free_run_i,
    input wire logic lsb_first_select_i,
    input wire logic sync_edge_alignment_i,
    input wire logic select_offset_mode_i,
    input wire logic [DELAY_W-1:0] slot_frame_delay_i,
    input wire logic [WSIZE_W-1:0] window_size_i,
    input wire logic [INDEX_W-1:0] window_offset_i,
    input wire logic [PFD_W-1:0] prefetch_distance_limit_i,
    input wire logic [DIV_W-1:0] sync_interval_i,
    input wire logic [SLOT_MAX-1:0] tx_slot_select_i,
    input wire logic [SLOT_MAX-1:0] rx_slot_select_i,
    // buffers and status
    input wire logic tx_write_i,
    input wire logic [WORD_BITS-1:0] tx_buffer_i,
    output logic [WORD_BITS-1:0] rx_buffer_o,
    output logic rx_valid_o,
    input wire logic underflow_clear_i,
    output logic tx_underflow_flag_o,
    // link
    input wire logic sclk_i,
    input wire logic rx_frame_sync_i,
    output logic rx_frame_sync_o,
    output logic rx_frame_sync_oe_b_o,
    input wire logic tx_frame_sync_i,
    output logic tx_frame_sync_o,
    output logic tx_frame_sync_oe_b_o,
    input wire logic serial_data_in_i,
    output logic serial_data_out_o,
    output logic serial_data_oe_b_o,
    output logic [INDEX_W-1:0] current_slot_index_o,
    output logic [SLOT_W-1:0] prefetch_limit_o
);

    // ************************************
    // elaboration checks
    // ************************************
    if (WORD_BITS < WORD_BITS_MIN || WORD_BITS > (1 << BIT_W)) begin : g_chk
        $error("WORD_BITS out of range");
    end

    localparam int CFG_W = 8 + DELAY_W + WSIZE_W + INDEX_W + 1 + PFD_W + DIV_W
        + 2 * SLOT_MAX;
    localparam logic [BIT_W-1:0] BIT_LAST = BIT_W'(WORD_BITS - 1);

    // ************************************
    // slot decode
    // ************************************
    function automatic logic slot_on(
        input logic [SLOT_MAX-1:0] map,
        input logic [SLOT_W-1:0] slot,
        input logic [SLOT_W-1:0] off,
        input logic [SLOT_W:0] size,
        input logic offm
    );
        logic [SLOT_W:0] top;
        logic [SLOT_W-1:0] idx;
        top = {1'b0, off} + size;
        idx = offm ? slot - off : slot;
        slot_on = 1'b0;
        if (slot >= off && {1'b0, slot} < top && !(!offm && top > (SLOT_W+1)'(SLOT_MAX)))
            slot_on = map[idx[INDEX_W-1:0]];
    endfunction : slot_on

    // ************************************
    // system domain: transmit buffer
    // ************************************
    logic [WORD_BITS-1:0] tx_hold_reg;
    logic tx_tgl_reg;

    // buffer write launches a word toggle
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            tx_hold_reg <= WORD_RST[WORD_BITS-1:0];
            tx_tgl_reg <= 1'b0;
        end else if (tx_write_i) begin
            tx_hold_reg <= tx_buffer_i;
            tx_tgl_reg <= ~tx_tgl_reg;
        end
    end

    // ************************************
    // link domain: synchronisers
    // ************************************
    logic [CFG_W-1:0] cfg_meta_reg;
    logic [CFG_W-1:0] cfg_reg;
    logic [1:0] tt_reg;
    logic tt_seen_reg;

    // config and word toggle pass two flops
    always_ff @(posedge sclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cfg_meta_reg <= '0;
            cfg_reg <= '0;
            tt_reg <= 2'b00;
        end else begin
            cfg_meta_reg <= {tx_port_enable_i, rx_port_enable_i, multichannel_enable_i,
                tx_sync_internal_i, rx_sync_internal_i, tx_sync_free_run_i,
                lsb_first_select_i, sync_edge_alignment_i, slot_frame_delay_i,
                window_size_i, window_offset_i, select_offset_mode_i,
                prefetch_distance_limit_i, sync_interval_i, tx_slot_select_i,
                rx_slot_select_i};
            cfg_reg <= cfg_meta_reg;
            tt_reg <= {tt_reg[0], tx_tgl_reg};
        end
    end

    logic c_txen, c_rxen, c_mcm, c_tx_sync_internal, c_irfs, c_free, c_lsb, c_sync_edge_alignment, c_offm;
    logic [DELAY_W-1:0] c_mfd;
    logic [WSIZE_W-1:0] c_wsize;
    logic [INDEX_W-1:0] c_woff;
    logic [PFD_W-1:0] c_pfd;
    logic [DIV_W-1:0] c_div;
    logic [SLOT_MAX-1:0] c_tmap;
    logic [SLOT_MAX-1:0] c_rmap;

    // unpack synchronised config
    assign {c_txen, c_rxen, c_mcm, c_tx_sync_internal, c_irfs, c_free, c_lsb, c_sync_edge_alignment, c_mfd,
        c_wsize, c_woff, c_offm, c_pfd, c_div, c_tmap, c_rmap} = cfg_reg;

    // ************************************
    // link domain: frame engine
    // ************************************
    frame_state_e st_reg;
    logic [DIV_W-1:0] div_reg;
    logic [(1 << DELAY_W)-1:0] fs_line_reg;
    logic [SLOT_W-1:0] slot_reg;
    logic [BIT_W-1:0] bit_reg;
    logic [WORD_BITS-1:0] shift_reg;
    logic [WORD_BITS-1:0] rx_shift_reg;
    logic [WORD_BITS-1:0] rx_word_reg;
    logic tx_act_reg, rx_act_reg, uf_tgl_reg, rx_tgl_reg, dout_neg_reg;
    logic [INDEX_W-1:0] cur_reg;
    logic [SLOT_W-1:0] pf_reg;

    logic tick, new_word, fs_evt, fs_go, bit_last, frame_end, accept, start_n, word_start;
    logic [SLOT_W:0] wsize;
    logic [SLOT_W:0] total;
    logic [SLOT_W-1:0] slot_nx;
    logic tx_on_nx, rx_on_nx;

    // sync interval, window and frame decode
    assign tick = (div_reg == '0);
    assign new_word = (tt_reg[1] != tt_seen_reg);
    assign wsize = (SLOT_W+1)'({c_wsize, 3'b000}) + (SLOT_W+1)'(1 << WIN_STEP_LOG);
    assign total = {1'b0, 1'b0, c_woff} + wsize;
    assign fs_evt = c_irfs ? tick : rx_frame_sync_i;
    assign bit_last = (st_reg == ST_RUN) && (bit_reg == BIT_LAST);
    assign frame_end = bit_last && ({1'b0, slot_reg} == total - 1'b1);
    assign fs_go = (c_mfd == '0) ? fs_evt : fs_line_reg[c_mfd - 1'b1];
    assign accept = c_mcm && fs_go && (st_reg != ST_RUN || frame_end);
    assign start_n = !c_mcm && c_txen && (st_reg == ST_IDLE || bit_last)
        && (c_tx_sync_internal ? tick && (c_free || new_word) : tx_frame_sync_i);
    assign word_start = accept
        || (c_mcm && bit_last && !frame_end) || start_n;
    assign slot_nx = (c_mcm && st_reg == ST_RUN && !frame_end) ? slot_reg + 1'b1 : '0;
    assign tx_on_nx = c_txen && (!c_mcm
        || slot_on(c_tmap, slot_nx, {1'b0, c_woff}, wsize, c_offm));
    assign rx_on_nx = c_rxen && (!c_mcm
        || slot_on(c_rmap, slot_nx, {1'b0, c_woff}, wsize, c_offm));

    // internal sync interval counter
    always_ff @(posedge sclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            div_reg <= '0;
        end else begin
            div_reg <= tick ? c_div : div_reg - 1'b1;
        end
    end

    // frame sync delay line, lets the next sync land inside the running frame
    always_ff @(posedge sclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            fs_line_reg <= '0;
        end else begin
            fs_line_reg <= {fs_line_reg[(1 << DELAY_W)-2:0], fs_evt};
        end
    end

    // frame state, slot and bit counters
    always_ff @(posedge sclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            st_reg <= ST_IDLE;
            slot_reg <= '0;
            bit_reg <= '0;
        end else if (!c_mcm && !c_txen) begin
            st_reg <= ST_IDLE;
            bit_reg <= '0;
        end else if (word_start) begin
            st_reg <= ST_RUN;
            slot_reg <= slot_nx;
            bit_reg <= '0;
        end else if (c_mcm && fs_evt && c_mfd != '0 && st_reg == ST_IDLE) begin
            st_reg <= ST_DELAY;
        end else begin
            unique case (st_reg)
                ST_IDLE: st_reg <= ST_IDLE;
                ST_DELAY: begin
                    if (!c_mcm) begin
                        st_reg <= ST_IDLE;
                    end
                end
                ST_RUN: begin
                    bit_reg <= bit_reg + 1'b1;
                    if (bit_last) begin
                        st_reg <= ST_IDLE;
                    end
                end
                default: st_reg <= ST_IDLE;
            endcase
        end
    end

    // transmit shifter, word hand-off and underflow event
    always_ff @(posedge sclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            shift_reg <= WORD_RST[WORD_BITS-1:0];
            tx_act_reg <= 1'b0;
            tt_seen_reg <= 1'b0;
            uf_tgl_reg <= 1'b0;
        end else if (word_start) begin
            tx_act_reg <= tx_on_nx;
            if (tx_on_nx) begin
                shift_reg <= tx_hold_reg;
                tt_seen_reg <= tt_reg[1];
                if (!new_word) begin
                    uf_tgl_reg <= ~uf_tgl_reg;
                end
            end
        end else if (bit_last || (!c_mcm && !c_txen)) begin
            tx_act_reg <= 1'b0;
        end else if (st_reg == ST_RUN) begin
            shift_reg <= c_lsb ? shift_reg >> 1 : shift_reg << 1;
        end
    end

    // receive shifter runs in every slot, words kept from enabled receive slots
    always_ff @(posedge sclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rx_shift_reg <= WORD_RST[WORD_BITS-1:0];
            rx_word_reg <= WORD_RST[WORD_BITS-1:0];
            rx_act_reg <= 1'b0;
            rx_tgl_reg <= 1'b0;
        end else begin
            if (word_start) begin
                rx_act_reg <= rx_on_nx;
            end
            // first bit is sampled on the edge that starts the word
            if (word_start || (st_reg == ST_RUN && !bit_last)) begin
                rx_shift_reg <= c_lsb ? {serial_data_in_i, rx_shift_reg[WORD_BITS-1:1]}
                    : {rx_shift_reg[WORD_BITS-2:0], serial_data_in_i};
            end
            if (bit_last && rx_act_reg) begin
                rx_word_reg <= rx_shift_reg;
                rx_tgl_reg <= ~rx_tgl_reg;
            end
        end
    end

    // slot index and prefetch limit
    always_ff @(posedge sclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            cur_reg <= '0;
            pf_reg <= '0;
        end else if (word_start && c_mcm) begin
            cur_reg <= (c_offm && slot_nx >= {1'b0, c_woff}) ?
                INDEX_W'(slot_nx - {1'b0, c_woff}) : slot_nx[INDEX_W-1:0];
            pf_reg <= slot_nx + (PREFETCH_BASE << c_pfd);
        end
    end

    // falling edge copy of the data bit
    always_ff @(negedge sclk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            dout_neg_reg <= 1'b0;
        end else begin
            dout_neg_reg <= c_lsb ? shift_reg[0] : shift_reg[WORD_BITS-1];
        end
    end

    // ************************************
    // link outputs
    // ************************************
    // data pin, sync pins and status
    assign serial_data_out_o = c_sync_edge_alignment ? dout_neg_reg
        : (c_lsb ? shift_reg[0] : shift_reg[WORD_BITS-1]);
    assign serial_data_oe_b_o = !(c_txen && (!c_mcm || tx_act_reg));
    assign tx_frame_sync_o = c_mcm ? tx_act_reg : (c_tx_sync_internal && st_reg == ST_RUN);
    assign tx_frame_sync_oe_b_o = !(c_mcm || c_tx_sync_internal);
    assign rx_frame_sync_o = c_irfs && tick;
    assign rx_frame_sync_oe_b_o = !c_irfs;
    assign current_slot_index_o = cur_reg;
    assign prefetch_limit_o = pf_reg;

    // ************************************
    // system domain: status return
    // ************************************
    logic [2:0] uf_sync_reg;
    logic [2:0] rx_sync_reg;

    // underflow sticky flag, set wins over clear
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            uf_sync_reg <= 3'b000;
            tx_underflow_flag_o <= 1'b0;
        end else begin
            uf_sync_reg <= {uf_sync_reg[1:0], uf_tgl_reg};
            if (uf_sync_reg[2] != uf_sync_reg[1]) begin
                tx_underflow_flag_o <= 1'b1;
            end else if (underflow_clear_i) begin
                tx_underflow_flag_o <= 1'b0;
            end
        end
    end

    // received word hand-off
    always_ff @(posedge clk_i or negedge rst_b_i) begin
        if (!rst_b_i) begin
            rx_sync_reg <= 3'b000;
            rx_buffer_o <= WORD_RST[WORD_BITS-1:0];
            rx_valid_o <= 1'b0;
        end else begin
            rx_sync_reg <= {rx_sync_reg[1:0], rx_tgl_reg};
            rx_valid_o <= (rx_sync_reg[2] != rx_sync_reg[1]);
            if (rx_sync_reg[2] != rx_sync_reg[1]) begin
                rx_buffer_o <= rx_word_reg;
            end
        end
    end

    // ************************************
    // checks
    // ************************************
    a_slot_restart: assert property (@(posedge sclk_i) disable iff (!rst_b_i)
        accept |=> st_reg == ST_RUN && slot_reg == '0 && bit_reg == '0)
        else $error("frame did not restart at slot zero");

    a_frame_delay: assert property (@(posedge sclk_i) disable iff (!rst_b_i)
        c_mcm && fs_evt && c_mfd == 4'h3 && st_reg == ST_IDLE && !word_start
        && fs_line_reg[1:0] == 2'b00 |=> st_reg == ST_DELAY ##1 st_reg == ST_DELAY
        ##1 st_reg == ST_DELAY ##1 st_reg == ST_RUN)
        else $error("frame delay length wrong");

    a_data_release: assert property (@(posedge sclk_i) disable iff (!rst_b_i)
        c_mcm && !tx_act_reg |-> serial_data_oe_b_o)
        else $error("data driven in inactive slot");

    a_valid_strobe: assert property (@(posedge sclk_i) disable iff (!rst_b_i)
        c_mcm && c_txen && tx_frame_sync_o |-> !serial_data_oe_b_o && !tx_frame_sync_oe_b_o)
        else $error("sync strobe without data");

    a_sync_waits: assert property (@(posedge sclk_i) disable iff (!rst_b_i)
        !c_mcm && c_tx_sync_internal && !c_free && !new_word && st_reg == ST_IDLE
        |=> st_reg == ST_IDLE)
        else $error("internal sync without new word");

    a_free_run: assert property (@(posedge sclk_i) disable iff (!rst_b_i)
        !c_mcm && c_txen && c_tx_sync_internal && c_free && tick && st_reg == ST_IDLE
        |=> st_reg == ST_RUN && bit_reg == '0)
        else $error("free running sync missed");

    a_underflow_evt: assert property (@(posedge sclk_i) disable iff (!rst_b_i)
        word_start && tx_on_nx && !new_word |=> uf_tgl_reg != $past(uf_tgl_reg))
        else $error("stale word not flagged");

    a_window_invalid: assert property (@(posedge sclk_i) disable iff (!rst_b_i)
        c_mcm && !c_offm && total > 9'd128 && word_start |=> !tx_act_reg && !rx_act_reg)
        else $error("slot enabled in invalid window");

    a_flag_sticky: assert property (@(posedge clk_i) disable iff (!rst_b_i)
        tx_underflow_flag_o && !underflow_clear_i |=> tx_underflow_flag_o)
        else $error("underflow flag lost");

endmodule : tdm_serial_port_framing

//--- test_tdm_serial_port_framing.sv
// Purpose: self-checking bench for the tdm framing block
// Assumes: the far device model supplies bus clock and frame sync
// Notes: expected words wait in queues until the outputs show them
`timescale 1ns/1ps

module test_tdm_serial_port_framing import tdm_pkg::*; ();
    logic clk_i, rst_b_i, tx_port_enable_i, rx_port_enable_i, multichannel_enable_i;
    logic tx_sync_internal_i, rx_sync_internal_i, tx_sync_free_run_i, lsb_first_select_i;
    logic sync_edge_alignment_i, select_offset_mode_i, tx_write_i, underflow_clear_i;
    logic tx_frame_sync_i, rx_valid_o, tx_underflow_flag_o, rx_frame_sync_o;
    logic rx_frame_sync_oe_b_o, tx_frame_sync_o, tx_frame_sync_oe_b_o;
    logic serial_data_out_o, serial_data_oe_b_o, sclk, rx_fs, sdi, run, on;
    logic [DELAY_W-1:0] slot_frame_delay_i;
    logic [WSIZE_W-1:0] window_size_i;
    logic [INDEX_W-1:0] window_offset_i, current_slot_index_o, idx;
    logic [PFD_W-1:0] prefetch_distance_limit_i;
    logic [DIV_W-1:0] sync_interval_i;
    logic [SLOT_MAX-1:0] tx_slot_select_i, rx_slot_select_i;
    logic [15:0] tx_buffer_i, rx_buffer_o, word, tx_word, acc, last_exp;
    logic [SLOT_W-1:0] prefetch_limit_o;
    logic [15:0] txq[$], rxq[$];
    int errors, tests_run, cyc, n, words_seen, seed, j, s, per;
    int cfg[5][4] = '{'{0, 0, 0, 0}, '{8, 0, 1, 15}, '{8, 1, 0, -1}, '{124, 0, 0, 3},
        '{0, 15, 0, 7}};

    // design and far device
    tdm_serial_port_framing i_tdm_serial_port_framing (
        .clk_i, .rst_b_i, .tx_port_enable_i, .rx_port_enable_i, .multichannel_enable_i,
        .tx_sync_internal_i, .rx_sync_internal_i, .tx_sync_free_run_i, .lsb_first_select_i,
        .sync_edge_alignment_i, .select_offset_mode_i, .slot_frame_delay_i, .window_size_i,
        .window_offset_i, .prefetch_distance_limit_i, .sync_interval_i, .tx_slot_select_i,
        .rx_slot_select_i, .tx_write_i, .tx_buffer_i, .rx_buffer_o, .rx_valid_o,
        .underflow_clear_i, .tx_underflow_flag_o, .sclk_i(sclk), .rx_frame_sync_i(rx_fs),
        .rx_frame_sync_o, .rx_frame_sync_oe_b_o, .tx_frame_sync_i, .tx_frame_sync_o,
        .tx_frame_sync_oe_b_o, .serial_data_in_i(sdi), .serial_data_out_o,
        .serial_data_oe_b_o, .current_slot_index_o, .prefetch_limit_o);
    tdm_partner i_tdm_partner (.run_i(run), .delay_i(slot_frame_delay_i),
        .period_i(16'(per)), .glitch_i(16'd40), .sclk_o(sclk), .fs_o(rx_fs), .sdi_o(sdi),
        .cyc_o(cyc), .word_o(word));

    // ****
    // helpers
    // ****
    task automatic chk(input logic [15:0] seen, input logic [15:0] exp);
        tests_run++;
        if (seen !== exp) begin
            errors++;
            $display("[FAIL] t=%0t seen=%h exp=%h", $time, seen, exp);
        end
    endtask : chk
    task automatic stop_test;
        $display("errors=%0d tests_run=%0d", errors, tests_run);
        if (errors == 0 && tests_run > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : stop_test
    task automatic sclk_wait(input int k);
        repeat (k) @(posedge sclk);
        @(posedge clk_i);
    endtask : sclk_wait
    task automatic wr(input logic [15:0] w);
        @(posedge clk_i);
        tx_buffer_i <= w;
        tx_write_i <= 1'b1;
        if (!multichannel_enable_i) txq.push_back(lsb_first_select_i ? {<<{w}} : w);
        @(posedge clk_i);
        tx_write_i <= 1'b0;
    endtask : wr
    task automatic wait_words(input int k);
        for (int i = 0; i < 200 && words_seen < k; i++) @(posedge sclk);
        chk(16'(words_seen >= k), 16'h0001);
    endtask : wait_words
    function automatic logic slot_on(input logic [SLOT_MAX-1:0] map, input int k);
        int off;
        int tot;
        off = window_offset_i;
        tot = off + (window_size_i + 1) * 8;
        if (!select_offset_mode_i && tot > 128) return 1'b0;
        if (k < off || k >= tot) return 1'b0;
        if (select_offset_mode_i) return map[k - off];
        return map[k];
    endfunction : slot_on

    // system clock
    initial begin
        clk_i = 1'b0;
        forever #20 clk_i = ~clk_i;
    end

    // link watcher: serial words, slot strobes, slot index, receive notes
    always @(negedge sclk) begin
        if (!multichannel_enable_i && tx_frame_sync_o === 1'b1) begin
            acc = {acc[14:0], serial_data_out_o};
            n++;
            if (n == 16) begin
                if (txq.size() > 0) last_exp = txq.pop_front();
                chk(acc, last_exp);
                n = 0;
                words_seen++;
            end
        end
        if (multichannel_enable_i && run && cyc >= 0 && cyc < 2 * per + slot_frame_delay_i) begin
            j = cyc - slot_frame_delay_i;
            s = j < 0 ? 0 : j % per / 16;
            on = j >= 0 && slot_on(tx_slot_select_i, s);
            chk(16'(tx_frame_sync_o), 16'(on));
            chk(16'(serial_data_oe_b_o), 16'(!on));
            chk(16'({tx_frame_sync_oe_b_o, rx_frame_sync_oe_b_o, rx_frame_sync_o}), 16'h0002);
            if (on) chk(16'(serial_data_out_o), 16'(tx_word[15 - j % 16]));
            if (j >= 0 && j % 16 == 8) begin
                idx = 7'(select_offset_mode_i && s >= window_offset_i ? s - window_offset_i : s);
                chk(16'(current_slot_index_o), 16'(idx));
                chk(16'(prefetch_limit_o),
                    16'(8'(s) + (PREFETCH_BASE << prefetch_distance_limit_i)));
            end
            if (j >= 0 && j % 16 == 15 && slot_on(rx_slot_select_i, s)) rxq.push_back(word);
        end
    end

    // received words against the oldest note
    always @(posedge clk_i) begin
        if (rx_valid_o === 1'b1) begin
            if (rxq.size() == 0) chk(16'h0001, 16'h0000);
            else chk(rx_buffer_o, rxq.pop_front());
        end
    end

    // watchdog
    initial begin
        #3000000;
        errors++;
        stop_test();
    end

    // main sequence
    initial begin
        {rst_b_i, tx_port_enable_i, rx_port_enable_i, multichannel_enable_i, run} = '0;
        {tx_sync_internal_i, rx_sync_internal_i, tx_sync_free_run_i, lsb_first_select_i} = '0;
        {sync_edge_alignment_i, select_offset_mode_i, tx_write_i, underflow_clear_i} = '0;
        {tx_frame_sync_i, slot_frame_delay_i, window_size_i, window_offset_i} = '0;
        {prefetch_distance_limit_i, tx_slot_select_i, rx_slot_select_i, tx_buffer_i} = '0;
        {errors, tests_run, n, words_seen, last_exp, tx_word} = '0;
        sync_interval_i = 8'h1f;
        per = 128;
        seed = 32'h210c1573;
        repeat (10) @(posedge clk_i);
        rst_b_i <= 1'b1;
        tx_port_enable_i <= 1'b1;
        tx_sync_internal_i <= 1'b1;
        sclk_wait(100);
        chk(16'(words_seen), 16'h0000);
        chk(16'(serial_data_oe_b_o), 16'h0000);
        wr(16'($random(seed)));
        wait_words(1);
        chk(16'(tx_underflow_flag_o), 16'h0000);
        tx_sync_free_run_i <= 1'b1;
        wait_words(3);
        tx_sync_free_run_i <= 1'b0;
        sclk_wait(40);
        chk(16'(tx_underflow_flag_o), 16'h0001);
        underflow_clear_i <= 1'b1;
        sclk_wait(1);
        underflow_clear_i <= 1'b0;
        lsb_first_select_i <= 1'b1;
        wr(16'($random(seed)));
        wait_words(4);
        chk(16'(tx_underflow_flag_o), 16'h0000);
        tx_sync_internal_i <= 1'b0;
        sclk_wait(4);
        tx_frame_sync_i <= 1'b1;
        sclk_wait(1);
        tx_frame_sync_i <= 1'b0;
        sclk_wait(20);
        chk(16'(tx_underflow_flag_o), 16'h0001);
        tx_port_enable_i <= 1'b0;
        lsb_first_select_i <= 1'b0;
        $display("test normal mode done");
        for (int r = 0; r < 5; r++) begin
            multichannel_enable_i <= 1'b1;
            window_offset_i <= 7'(cfg[r][0]);
            window_size_i <= 4'(cfg[r][1]);
            select_offset_mode_i <= cfg[r][2] != 0;
            slot_frame_delay_i <= cfg[r][3] < 0 ? 4'($unsigned($random(seed))) : 4'(cfg[r][3]);
            prefetch_distance_limit_i <= 2'(r);
            tx_slot_select_i <= {$random(seed), $random(seed), $random(seed), $random(seed)};
            rx_slot_select_i <= {$random(seed), $random(seed), $random(seed), $random(seed)};
            per = (cfg[r][0] + (cfg[r][1] + 1) * 8) * 16;
            sclk_wait(4);
            tx_port_enable_i <= 1'b1;
            rx_port_enable_i <= 1'b1;
            tx_word = 16'($random(seed));
            wr(tx_word);
            sclk_wait(4);
            run <= 1'b1;
            sclk_wait(2 * per + slot_frame_delay_i + 4);
            run <= 1'b0;
            tx_port_enable_i <= 1'b0;
            rx_port_enable_i <= 1'b0;
            sclk_wait(4);
            chk(16'(rxq.size()), 16'h0000);
            rxq.delete();
            multichannel_enable_i <= 1'b0;
            sclk_wait(4);
            $display("test multichannel row %0d done", r);
        end
        stop_test();
    end
endmodule : test_tdm_serial_port_framing
